// ==== dv/irh_core_model.sv ====
// Behavioural core: completes instructions and, on request, return instructions.
// Assumes the handler samples both strobes on rising edges of ref_clk.
`timescale 1ns/1ps
`default_nettype none
module irh_core_model (
	input  wire logic ref_clk,              // System clock
	input  wire logic rst_b,                // Reset, active low
	input  wire logic slow,                 // One boundary every third cycle
	input  wire logic ret_req,              // Bench asks for a return
	output logic      instr_boundary,       // Instruction completes
	output logic      return_from_interrupt // Return instruction completes
);
	logic [1:0] cnt_reg; // Cycles left in the running instruction

	// No boundary shares a cycle with a return, so the handler's tie rule never matters
	always_ff @(posedge ref_clk or negedge rst_b) begin
		if (!rst_b) begin
			cnt_reg               <= 2'h0;
			instr_boundary        <= 1'b0;
			return_from_interrupt <= 1'b0;
		end else begin
			cnt_reg               <= (cnt_reg != 2'h0) ? cnt_reg - 2'h1 : (slow ? 2'h2 : 2'h0);
			return_from_interrupt <= ret_req && !return_from_interrupt;
			instr_boundary        <= (cnt_reg == 2'h0) && !(ret_req && !return_from_interrupt);
		end
	end
endmodule : irh_core_model
`default_nettype wire

// ==== dv/irh_handler_tb_top.sv ====
// Self-checking bench for the interrupt request handler with a core model.
// Assumes the handler and core model sources are compiled before this file.
`timescale 1ns/1ps
`default_nettype none
module irh_handler_tb_top
	import irh_pkg::*;
;
	logic             ref_clk, rst_b, ier_wr, ext_en_wr, prio_wr, slow, ret_req;
	logic [NSRC-1:0]  src_event, flag_set, flag_clr, prio_wdata, prio_level, pending;
	logic [7:0]       ier_wdata, ext_en_wdata, interrupt_enable_register, ext_enable;
	logic             instr_boundary, return_from_interrupt, long_subroutine_call;
	logic             in_service_low, in_service_high;
	logic [VEC_W-1:0] vector_addr;
	logic [SRC_W-1:0] call_src;
	int               fails, checks_done;

	irh_handler u_irh_handler (.ref_clk(ref_clk), .rst_b(rst_b), .src_event(src_event),
		.flag_set(flag_set), .flag_clr(flag_clr), .ier_wr(ier_wr), .ier_wdata(ier_wdata),
		.ext_en_wr(ext_en_wr), .ext_en_wdata(ext_en_wdata), .prio_wr(prio_wr),
		.prio_wdata(prio_wdata), .instr_boundary(instr_boundary),
		.return_from_interrupt(return_from_interrupt),
		.interrupt_enable_register(interrupt_enable_register), .ext_enable(ext_enable),
		.prio_level(prio_level), .pending(pending), .long_subroutine_call(long_subroutine_call),
		.vector_addr(vector_addr), .call_src(call_src), .in_service_low(in_service_low),
		.in_service_high(in_service_high));
	irh_core_model u_irh_core_model (.ref_clk(ref_clk), .rst_b(rst_b), .slow(slow),
		.ret_req(ret_req), .instr_boundary(instr_boundary),
		.return_from_interrupt(return_from_interrupt));

	// Clock at 25 MHz
	initial begin
		ref_clk = 1'b0;
		forever #20 ref_clk = ~ref_clk;
	end

	task chk(input string n, input logic [15:0] s, input logic [15:0] e);
		checks_done++;
		if (s !== e) begin
			fails++;
			$display("Error %s expected %h seen %h", n, e, s);
		end
	endtask : chk

	task end_of_test;
		$display("Checks %0d mismatches %0d", checks_done, fails);
		if (fails == 0 && checks_done > 0) $display("Result: passed");
		else $display("Result: failed");
		$finish;
	endtask : end_of_test

	// Let n edges pass, then look once their updates have landed
	task cyc(input int n);
		repeat (n) @(posedge ref_clk);
		#1;
	endtask : cyc

	// All three configuration words in one cycle, then readback
	task cfg(input logic [7:0] ie, input logic [7:0] ex, input logic [14:0] pr);
		@(posedge ref_clk);
		{ier_wr, ext_en_wr, prio_wr} <= 3'h7;
		{ier_wdata, ext_en_wdata, prio_wdata} <= {ie, ex, pr};
		@(posedge ref_clk);
		{ier_wr, ext_en_wr, prio_wr} <= 3'h0;
		#1;
		chk("ier", interrupt_enable_register, ie);
		chk("ext", ext_enable, ex);
		chk("prio", prio_level, pr);
	endtask : cfg

	task pulse(input logic [14:0] ev, input logic [14:0] st, input logic [14:0] cl);
		@(posedge ref_clk);
		{src_event, flag_set, flag_clr} <= {ev, st, cl};
		@(posedge ref_clk);
		{src_event, flag_set, flag_clr} <= 45'h0;
	endtask : pulse

	task ret;
		@(posedge ref_clk);
		ret_req <= 1'b1;
		@(posedge ref_clk);
		ret_req <= 1'b0;
	endtask : ret

	// Bounded wait for a call, then judge where it went
	task wait_call(input logic [3:0] s);
		logic seen;
		seen = 1'b0;
		for (int i = 0; i < 20 && !seen; i++) begin
			cyc(1);
			seen = (long_subroutine_call === 1'b1);
		end
		chk("call", seen, 16'h1);
		chk("src", call_src, s);
		chk("vector", vector_addr, 16'h0003 + 16'h0008 * s);
	endtask : wait_call

	task no_call(input int n);
		logic seen;
		seen = 1'b0;
		repeat (n) begin
			cyc(1);
			if (long_subroutine_call !== 1'b0) seen = 1'b1;
		end
		chk("no call", seen, 16'h0);
	endtask : no_call

	task t_reset;
		chk("ier", interrupt_enable_register, 16'h0);
		chk("ext", ext_enable, 16'h0);
		chk("prio", prio_level, 16'h0);
		chk("svc", {in_service_high, in_service_low}, 16'h0);
		chk("pending", pending, 16'h0);
		chk("call", long_subroutine_call, 16'h0);
		chk("vector", vector_addr, 16'h0);
		chk("src", call_src, 16'h0);
		$display("test reset done");
	endtask : t_reset

	task t_mask;
		cfg(8'h20, 8'h00, 15'h0000);
		pulse(15'h0020, 15'h0, 15'h0);
		no_call(8);
		chk("pending", pending, 16'h0020);
		cfg(8'h80, 8'h00, 15'h0000);
		no_call(4);
		cfg(8'ha0, 8'h00, 15'h0000);
		wait_call(4'h5);
		chk("kept", pending[5], 16'h1);
		chk("low", in_service_low, 16'h1);
		ret();
		cyc(1);
		chk("low end", in_service_low, 16'h0);
		cyc(1);
		chk("hold", long_subroutine_call, 16'h0);
		cyc(1);
		chk("reenter", long_subroutine_call, 16'h1);
		pulse(15'h0, 15'h0, 15'h0020);
		ret();
		no_call(6);
		chk("low off", in_service_low, 16'h0);
		$display("test mask done");
	endtask : t_mask

	task t_auto;
		cfg(8'h81, 8'h00, 15'h0000);
		@(posedge ref_clk);
		slow <= 1'b1;
		pulse(15'h0, 15'h0001, 15'h0);
		wait_call(4'h0);
		chk("auto clr", pending[0], 16'h0);
		@(posedge ref_clk);
		slow <= 1'b0;
		ret();
		no_call(4);
		$display("test auto done");
	endtask : t_auto

	task t_prio;
		cfg(8'h96, 8'h04, 15'h0004);
		pulse(15'h0, 15'h0006, 15'h0);
		wait_call(4'h2);
		chk("high", in_service_high, 16'h1);
		no_call(6);
		ret();
		wait_call(4'h1);
		pulse(15'h0, 15'h0004, 15'h0);
		wait_call(4'h2);
		chk("nest", {in_service_high, in_service_low}, 16'h3);
		ret();
		ret();
		no_call(4);
		chk("svc", {in_service_high, in_service_low}, 16'h0);
		pulse(15'h0, 15'h0210, 15'h0);
		wait_call(4'h4);
		pulse(15'h0, 15'h0, 15'h0010);
		ret();
		wait_call(4'h9);
		pulse(15'h0, 15'h0, 15'h0200);
		ret();
		no_call(6);
		chk("pending", pending, 16'h0);
		$display("test prio done");
	endtask : t_prio

	// Whole run is well under a thousand cycles; this cuts a hang short
	initial begin
		#200000;
		fails++;
		end_of_test();
	end

	// Reset, then the scenarios in turn
	initial begin
		{rst_b, ier_wr, ext_en_wr, prio_wr, slow, ret_req} = 6'h0;
		{src_event, flag_set, flag_clr, prio_wdata} = 60'h0;
		{ier_wdata, ext_en_wdata} = 16'h0;
		fails = 0;
		checks_done = 0;
		repeat (8) @(posedge ref_clk);
		rst_b <= 1'b1;
		cyc(4);
		t_reset();
		t_mask();
		t_auto();
		t_prio();
		end_of_test();
	end
endmodule : irh_handler_tb_top
`default_nettype wire

// ==== hw/irh_arbiter.sv ====
// Fixed-order two-level arbiter over the enabled pending sources.
// Assumes pending, enable and priority vectors are registered upstream.
`timescale 1ns/1ps
`default_nettype none
module irh_arbiter
	import irh_pkg::*;
(
	input  wire logic [NSRC-1:0]  pend,  // Pending flags
	input  wire logic [NSRC-1:0]  en,    // Effective enables, global already applied
	input  wire logic [NSRC-1:0]  prio,  // One selects high level
	output logic                  valid, // Some candidate exists
	output logic [SRC_W-1:0]      src,   // Winning source number
	output logic                  level  // Level of the winner
);

	// Scan ranks backwards so the lowest rank of the highest level is kept last
	always_comb begin
		logic [SRC_W-1:0] s;
		s     = '0;
		valid = 1'b0;
		src   = '0;
		level = 1'b0;
		// Low level pass first, the high pass overrides it
		for (int lv = 0; lv < 2; lv++) begin
			for (int r = NSRC - 1; r >= 0; r--) begin
				s = ORDER_TABLE[r];
				if (pend[s] && en[s] && (prio[s] == lv[0])) begin // [RULE14] [RULE1]
					valid = 1'b1;
					src   = s;
					level = lv[0];
				end
			end
		end
	end

endmodule : irh_arbiter
`default_nettype wire

// ==== hw/irh_handler.sv ====
// Interrupt request handler top: pending flags, enables, priorities, vectoring.
// Assumes the core pulses instr_boundary as each instruction completes and
// return_from_interrupt as its return instruction completes.
//
// Notes on behaviour
// [RULE1] Many sources, each on one of two levels
// [RULE2] Source condition sets its pending flag to one
// [RULE3] Request needs global and source enable both set
// [RULE4] Vector by long call after current instruction
// [RULE5] Service routine ends with return, resuming flow
// [RULE6] Disabled source flag is ignored, no vectoring
// [RULE7] Flags set whether or not source enabled
// [RULE8] Chosen sources auto-cleared when the call vectors
// [RULE9] Software clears other flags before returning
// [RULE10] Still-set flag re-enters after one instruction
// [RULE11] Global enable bit seven gates every source
// [RULE12] Requests held pending while global enable low
// [RULE13] High preempts low; high never preempted
// [RULE14] Higher level wins, then fixed source order
// [RULE15] Vectors and order kept in a table
// [RULE16] Reset clears enables, global enable, priorities
`timescale 1ns/1ps
`default_nettype none
module irh_handler
	import irh_pkg::*;
(
	input  wire logic              ref_clk,               // System clock, 25 MHz
	input  wire logic              rst_b,                 // Asynchronous reset, active low
	input  wire logic [NSRC-1:0]   src_event,             // Source conditions, one per source
	input  wire logic [NSRC-1:0]   flag_set,              // Software sets flags
	input  wire logic [NSRC-1:0]   flag_clr,              // Software clears flags
	input  wire logic              ier_wr,                // Write the enable register
	input  wire logic [7:0]        ier_wdata,             // Global enable and sources 0..6
	input  wire logic              ext_en_wr,             // Write the extended enables
	input  wire logic [7:0]        ext_en_wdata,          // Sources 7..14
	input  wire logic              prio_wr,               // Write all priority bits
	input  wire logic [NSRC-1:0]   prio_wdata,            // One selects high level
	input  wire logic              instr_boundary,        // Current instruction completes
	input  wire logic              return_from_interrupt, // Return instruction completes
	output logic [7:0]             interrupt_enable_register, // Enable register readback
	output logic [7:0]             ext_enable,            // Extended enable readback
	output logic [NSRC-1:0]        prio_level,            // Priority readback
	output logic [NSRC-1:0]        pending,               // Pending flags for polling
	output logic                   long_subroutine_call,  // One-cycle vector strobe
	output logic [VEC_W-1:0]       vector_addr,           // Vector of the last call
	output logic [SRC_W-1:0]       call_src,              // Source of the last call
	output logic                   in_service_low,        // Low-level routine running
	output logic                   in_service_high        // High-level routine running
);

	// Whole state of the handler
	typedef struct packed {
		logic [7:0]        ier;     // Global enable at bit 7, base enables below
		logic [7:0]        ext_en;  // Extended enables
		logic [NSRC-1:0]   prio;    // Level select per source
		logic [NSRC-1:0]   pend;    // Pending flags
		logic              in_low;  // Low routine active (may be preempted)
		logic              in_high; // High routine active
		irh_fsm_t          fsm;     // Run or hold-one-instruction
		logic              call;    // Vector strobe
		logic [VEC_W-1:0]  vec;     // Vector address
		logic [SRC_W-1:0]  src;     // Vectored source
		logic              lvl;     // Level of the vectored source
	} irh_state_t;

	localparam irh_state_t ST_RST = '{
		ier: IER_RST, ext_en: EXT_RST, prio: PRIO_RST, pend: PEND_RST,
		in_low: 1'b0, in_high: 1'b0, fsm: IRH_RUN, call: 1'b0,
		vec: '0, src: '0, lvl: 1'b0};

	irh_state_t        st_reg;     // Registered state
	irh_state_t        st_next;    // Next state
	logic [1:0]        rst_sync;   // Reset release synchroniser
	logic              rst_n_int;  // Synchronised reset, active low
	logic [NSRC-1:0]   eff_en;     // Enables with the global gate applied
	logic              arb_valid;  // Arbiter found a candidate
	logic [SRC_W-1:0]  arb_src;    // Arbiter winner
	logic              arb_level;  // Winner level
	logic              may_vector; // Level permits vectoring now

	// Release reset through two flops so all state leaves reset on one edge
	always_ff @(posedge ref_clk or negedge rst_b) begin
		if (!rst_b) begin
			rst_sync <= 2'b00;
		end else begin
			rst_sync <= {rst_sync[0], 1'b1};
		end
	end
	assign rst_n_int = rst_sync[1];

	// Global gate blocks every source regardless of its own bit
	assign eff_en = st_reg.ier[GE_BIT] ? {st_reg.ext_en, st_reg.ier[BASE_SRCS-1:0]}
	                                   : '0; // [RULE11] [RULE3] [RULE6]

	irh_arbiter u_arb (
		.pend  (st_reg.pend),
		.en    (eff_en),
		.prio  (st_reg.prio),
		.valid (arb_valid),
		.src   (arb_src),
		.level (arb_level)
	);

	// Idle core takes any level; low routine only yields to high; high never
	assign may_vector = !st_reg.in_high && (!st_reg.in_low || arb_level); // [RULE13]

	// Next-state logic
	always_comb begin
		st_next      = st_reg;
		st_next.call = 1'b0;
		// Configuration writes
		if (ier_wr) begin
			st_next.ier = ier_wdata;
		end
		if (ext_en_wr) begin
			st_next.ext_en = ext_en_wdata;
		end
		if (prio_wr) begin
			st_next.prio = prio_wdata;
		end
		// Software clear first so any set in the same cycle wins
		st_next.pend = st_reg.pend & ~flag_clr;
		// Vector only at a boundary, never in the return cycle or the held instruction
		case (st_reg.fsm)
			IRH_RUN: begin
				if (return_from_interrupt) begin
					st_next.fsm = IRH_HOLD; // [RULE10] [RULE5]
				end else if (instr_boundary && arb_valid && may_vector) begin // [RULE4] [RULE12]
					st_next.call = 1'b1;
					st_next.vec  = VEC_TABLE[arb_src]; // [RULE15]
					st_next.src  = arb_src;
					st_next.lvl  = arb_level;
					if (arb_level) begin
						st_next.in_high = 1'b1;
					end else begin
						st_next.in_low = 1'b1;
					end
					if (AUTO_CLR[arb_src]) begin
						st_next.pend[arb_src] = 1'b0; // [RULE8]
					end
				end
			end
			IRH_HOLD: begin
				// The one instruction after a return runs; then requests are taken again
				if (instr_boundary && !return_from_interrupt) begin
					st_next.fsm = IRH_RUN; // [RULE10]
				end
			end
			default: begin
				st_next.fsm = IRH_RUN;
			end
		endcase
		// Return ends the innermost routine, high before low
		if (return_from_interrupt) begin
			if (st_reg.in_high) begin
				st_next.in_high = 1'b0; // [RULE5] [RULE13]
			end else begin
				st_next.in_low = 1'b0;
			end
		end
		// Source and software sets win over every clear, enabled or not
		st_next.pend = st_next.pend | src_event | flag_set; // [RULE2] [RULE7]
	end

	// State register; reset clears enables and priorities
	always_ff @(posedge ref_clk or negedge rst_n_int) begin
		if (!rst_n_int) begin
			st_reg <= ST_RST; // [RULE16]
		end else begin
			st_reg <= st_next;
		end
	end

	// Outputs straight from the state flops
	assign interrupt_enable_register = st_reg.ier;
	assign ext_enable                = st_reg.ext_en;
	assign prio_level                = st_reg.prio;
	assign pending                   = st_reg.pend;
	assign long_subroutine_call      = st_reg.call;
	assign vector_addr               = st_reg.vec;
	assign call_src                  = st_reg.src;
	assign in_service_low            = st_reg.in_low;
	assign in_service_high           = st_reg.in_high;

	// Checks on flag setting and the vectoring decisions

	property p_call_needs_global;
		@(posedge ref_clk) disable iff (!rst_n_int)
		st_reg.call |-> $past(st_reg.ier[GE_BIT]);
	endproperty
	a_call_needs_global: assert property (p_call_needs_global) // [RULE11]
		else $error("Vector taken with global enable low");

	property p_call_needs_source_en;
		@(posedge ref_clk) disable iff (!rst_n_int)
		// Index the sampled vectors with the source of this call, not the one before it
		st_reg.call |-> ((($past(eff_en) & $past(st_reg.pend)) >> st_reg.src) & 15'h0001) != 15'h0000;
	endproperty
	a_call_needs_source_en: assert property (p_call_needs_source_en) // [RULE3]
		else $error("Vector taken for a disabled or idle source");

	property p_flag_sets_always;
		@(posedge ref_clk) disable iff (!rst_n_int)
		(|src_event) |=> ((st_reg.pend & $past(src_event)) == $past(src_event));
	endproperty
	a_flag_sets_always: assert property (p_flag_sets_always) // [RULE7]
		else $error("Source event did not set its flag");

	property p_call_at_boundary;
		@(posedge ref_clk) disable iff (!rst_n_int)
		st_reg.call |-> $past(instr_boundary) && !$past(return_from_interrupt);
	endproperty
	a_call_at_boundary: assert property (p_call_at_boundary) // [RULE4]
		else $error("Vector not at an instruction boundary");

	property p_autoclear;
		@(posedge ref_clk) disable iff (!rst_n_int)
		// A set in the vectoring cycle wins, so only calls without one are judged
		st_reg.call && AUTO_CLR[st_reg.src]
			&& ((($past(src_event) | $past(flag_set)) >> st_reg.src) & 15'h0001) == 15'h0000
			|-> !st_reg.pend[st_reg.src];
	endproperty
	a_autoclear: assert property (p_autoclear) // [RULE8]
		else $error("Auto-cleared flag still set after vectoring");

	property p_one_instr_after_return;
		@(posedge ref_clk) disable iff (!rst_n_int)
		// Neither the return cycle nor the held instruction may vector
		return_from_interrupt |=> (!st_reg.call) [*2];
	endproperty
	a_one_instr_after_return: assert property (p_one_instr_after_return) // [RULE10]
		else $error("Re-entered before one instruction ran");

	property p_high_not_preempted;
		@(posedge ref_clk) disable iff (!rst_n_int)
		st_reg.call |-> !$past(st_reg.in_high);
	endproperty
	a_high_not_preempted: assert property (p_high_not_preempted) // [RULE13]
		else $error("High routine was preempted");

	property p_low_preempt_by_high;
		@(posedge ref_clk) disable iff (!rst_n_int)
		st_reg.call && $past(st_reg.in_low) |-> st_reg.lvl && st_reg.in_high;
	endproperty
	a_low_preempt_by_high: assert property (p_low_preempt_by_high) // [RULE13]
		else $error("Low routine preempted by equal level");

	property p_high_wins;
		@(posedge ref_clk) disable iff (!rst_n_int)
		st_reg.call && !st_reg.lvl |-> (($past(st_reg.pend) & $past(eff_en) & $past(st_reg.prio)) == '0);
	endproperty
	a_high_wins: assert property (p_high_wins) // [RULE14]
		else $error("Low source won over a high candidate");

	property p_gated_hold;
		@(posedge ref_clk) disable iff (!rst_n_int)
		!st_reg.ier[GE_BIT] |=> !st_reg.call;
	endproperty
	a_gated_hold: assert property (p_gated_hold) // [RULE12]
		else $error("Vector while globally disabled");

endmodule : irh_handler
`default_nettype wire

// ==== hw/irh_pkg.sv ====
// Constants for the interrupt request handler: sizes, reset values, tables.
// Assumes one system clock; every user of these names imports the package.
package irh_pkg;

	// Number of interrupt sources and width of a source index
	localparam int          NSRC      = 15;
	localparam int          SRC_W     = 4;
	localparam int          VEC_W     = 16;

	// Enable register layout: bit 7 is the global enable, bits 6:0 enable sources 0 to 6
	localparam int          GE_BIT    = 7;
	localparam int          BASE_SRCS = 7;
	localparam logic [7:0]  IER_RST   = 8'h00;
	localparam logic [7:0]  EXT_RST   = 8'h00;
	localparam logic [14:0] PRIO_RST  = 15'h0000;
	localparam logic [14:0] PEND_RST  = 15'h0000;

	// Sources whose flag is cleared by the handler on vectoring
	localparam logic [14:0] AUTO_CLR  = 15'h000f;

	// Vector per source number (parameter table, varies by device variant)
	localparam logic [NSRC-1:0][VEC_W-1:0] VEC_TABLE = {
		16'h0073, 16'h006b, 16'h0063, 16'h005b, 16'h0053, 16'h004b, 16'h0043, 16'h003b,
		16'h0033, 16'h002b, 16'h0023, 16'h001b, 16'h0013, 16'h000b, 16'h0003};

	// Source number at each arbitration rank, rank 0 wins among equals
	localparam logic [NSRC-1:0][SRC_W-1:0] ORDER_TABLE = {
		4'he, 4'hd, 4'hc, 4'hb, 4'ha, 4'h9, 4'h8, 4'h7,
		4'h6, 4'h5, 4'h4, 4'h3, 4'h2, 4'h1, 4'h0};

	// Sequencer states
	typedef enum logic [0:0] {
		IRH_RUN  = 1'b0, // Vectoring allowed at an instruction boundary
		IRH_HOLD = 1'b1  // One instruction must run after a return
	} irh_fsm_t;

endpackage : irh_pkg
